// [rtl/usb_cmd_interp.sv]
// command interpreter between the usb input and output word fifos
// assumes fifo words are 16 bits, in_last marks the end of a buffer,
// and the crate bus answers each request with one ack and data word
`timescale 1ns/100ps
module usb_cmd_interp (
	input wire logic clk, // device clock, 125 MHz
	input wire logic sys_rst, // synchronous reset, active high
	input wire logic in_valid, // usb input fifo has a word
	input wire logic [15:0] in_data, // usb input fifo word
	input wire logic in_last, // word ends the host buffer
	output logic in_ready, // word taken this cycle
	output logic out_valid, // word offered to output fifo
	output logic [15:0] out_data, // word for output fifo
	input wire logic out_ready, // output fifo takes the word
	output logic resp_full, // response queued, host may read
	output logic wr_reject, // pulse: write refused, zero bytes
	output logic [15:0] action, // action register contents
	output logic acq_active, // acquisition running
	input wire logic prog_mode, // rotary selector in programming
	output logic logic_reset, // reset of configurable logic
	output logic crate_req, // pulse: run one crate command
	output logic [15:0] crate_cmd, // crate command word
	input wire logic crate_ack, // crate command finished
	input wire logic [15:0] crate_rdata // data from crate command
);
	usb_cmd_pkg::cmd_state_e state_q, ret_q;
	logic [15:0] op_q, addr_q, action_q, out_data_q, crate_cmd_q;
	logic [usb_cmd_pkg::LEN_W-1:0] ptr_q, len_reg_q, len_per_q;
	logic [14:0] rem_q;
	logic sel_q, out_valid_q, resp_full_q, wr_reject_q;
	logic crate_req_q, logic_reset_q;
	logic [15:0] reg_rd_data, per_rd_data, stk_rd_data;

	// stack type check, used for write headers and read selects
	function automatic logic is_stack(input logic [15:0] w);
		is_stack = (w == usb_cmd_pkg::STACK_REGULAR) ||
			(w == usb_cmd_pkg::STACK_PERIODIC);
	endfunction : is_stack

	// ----------------------------------------------------------------
	// decode of taken words
	// ----------------------------------------------------------------
	// input accepted only in word-consuming states
	assign in_ready = (state_q == usb_cmd_pkg::ST_IDLE) ||
		(state_q == usb_cmd_pkg::ST_REG_ADDR) ||
		(state_q == usb_cmd_pkg::ST_REG_DATA) ||
		(state_q == usb_cmd_pkg::ST_STK_WR) ||
		(state_q == usb_cmd_pkg::ST_STK_SEL) ||
		(state_q == usb_cmd_pkg::ST_EXE_CNT) ||
		(state_q == usb_cmd_pkg::ST_EXE_CMD);
	wire take = in_valid && in_ready;
	wire action_hit = (addr_q == usb_cmd_pkg::ACTION_ADDR);
	wire reg_wr = take && (state_q == usb_cmd_pkg::ST_REG_DATA) &&
		action_hit;
	wire toggle = take && (state_q == usb_cmd_pkg::ST_IDLE) &&
		(in_data == usb_cmd_pkg::CMD_RESET_TOGGLE) && prog_mode;
	wire stk_wr = take && (state_q == usb_cmd_pkg::ST_STK_WR);
	wire [usb_cmd_pkg::LEN_W-1:0] cur_depth = sel_q ?
		usb_cmd_pkg::LEN_W'(usb_cmd_pkg::PERIODIC_DEPTH) :
		usb_cmd_pkg::LEN_W'(usb_cmd_pkg::REGULAR_DEPTH);
	wire room = ptr_q < cur_depth; // words past the end are dropped
	wire we_reg = stk_wr && !sel_q && room;
	wire we_per = stk_wr && sel_q && room;
	wire [usb_cmd_pkg::LEN_W-1:0] cur_len = sel_q ? len_per_q : len_reg_q;
	wire [usb_cmd_pkg::LEN_W-1:0] ptr_inc = ptr_q + 1'b1;
	assign stk_rd_data = sel_q ? per_rd_data : reg_rd_data;

	// ----------------------------------------------------------------
	// stack memories
	// ----------------------------------------------------------------
	stack_ram #(
		.DEPTH(usb_cmd_pkg::REGULAR_DEPTH),
		.AW(usb_cmd_pkg::REGULAR_AW)
	) u_regular (
		.clk(clk),
		.wr_en(we_reg),
		.wr_addr(ptr_q[usb_cmd_pkg::REGULAR_AW-1:0]),
		.wr_data(in_data),
		.rd_addr(ptr_q[usb_cmd_pkg::REGULAR_AW-1:0]),
		.rd_data(reg_rd_data)
	);
	stack_ram #(
		.DEPTH(usb_cmd_pkg::PERIODIC_DEPTH),
		.AW(usb_cmd_pkg::PERIODIC_AW)
	) u_periodic (
		.clk(clk),
		.wr_en(we_per),
		.wr_addr(ptr_q[usb_cmd_pkg::PERIODIC_AW-1:0]),
		.wr_data(in_data),
		.rd_addr(ptr_q[usb_cmd_pkg::PERIODIC_AW-1:0]),
		.rd_data(per_rd_data)
	);

	// ----------------------------------------------------------------
	// action register and configurable logic reset
	// ----------------------------------------------------------------
	// register write and reset toggle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			action_q <= usb_cmd_pkg::ACTION_RESET;
			logic_reset_q <= 1'b0;
		end else begin
			if (reg_wr) begin
				action_q <= in_data;
			end
			if (toggle) begin
				logic_reset_q <= !logic_reset_q;
			end
		end
	end

	// stack lengths recorded at the end of each write buffer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			len_reg_q <= '0;
			len_per_q <= '0;
		end else if (stk_wr && in_last) begin
			if (sel_q) begin
				len_per_q <= room ? ptr_inc : ptr_q;
			end else begin
				len_reg_q <= room ? ptr_inc : ptr_q;
			end
		end else if (take && (state_q == usb_cmd_pkg::ST_IDLE) &&
			is_stack(in_data) && in_last) begin
			if (in_data == usb_cmd_pkg::STACK_PERIODIC) begin
				len_per_q <= '0;
			end else begin
				len_reg_q <= '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// command sequencer
	// ----------------------------------------------------------------
	// one buffer at a time, pushes wait in ST_PUSH for the fifo
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= usb_cmd_pkg::ST_IDLE;
			ret_q <= usb_cmd_pkg::ST_IDLE;
			op_q <= 16'h0000;
			addr_q <= 16'h0000;
			sel_q <= 1'b0;
			ptr_q <= '0;
			rem_q <= 15'h0000;
			out_valid_q <= 1'b0;
			out_data_q <= 16'h0000;
			resp_full_q <= 1'b0;
			wr_reject_q <= 1'b0;
			crate_req_q <= 1'b0;
			crate_cmd_q <= 16'h0000;
		end else begin
			wr_reject_q <= 1'b0;
			crate_req_q <= 1'b0;
			case (state_q)
			usb_cmd_pkg::ST_IDLE: begin
				if (take) begin
					resp_full_q <= 1'b0; // new buffer clears the flag
					op_q <= in_data;
					if (is_stack(in_data)) begin
						sel_q <= (in_data == usb_cmd_pkg::STACK_PERIODIC);
						ptr_q <= '0;
						if (!in_last) begin
							state_q <= usb_cmd_pkg::ST_STK_WR;
						end
					end else if (in_data == usb_cmd_pkg::CMD_REG_WRITE ||
						in_data == usb_cmd_pkg::CMD_REG_READ) begin
						state_q <= usb_cmd_pkg::ST_REG_ADDR;
					end else if (in_data == usb_cmd_pkg::CMD_STACK_READ) begin
						state_q <= usb_cmd_pkg::ST_STK_SEL;
					end else if (in_data == usb_cmd_pkg::CMD_EXECUTE) begin
						state_q <= usb_cmd_pkg::ST_EXE_CNT;
					end
				end
			end
			usb_cmd_pkg::ST_REG_ADDR: begin
				if (take) begin
					addr_q <= in_data;
					if (op_q == usb_cmd_pkg::CMD_REG_READ) begin
						out_data_q <= (in_data == usb_cmd_pkg::ACTION_ADDR) ?
							action_q : usb_cmd_pkg::READ_FILL;
						out_valid_q <= 1'b1;
						ret_q <= usb_cmd_pkg::ST_DONE;
						state_q <= usb_cmd_pkg::ST_PUSH;
					end else begin
						state_q <= usb_cmd_pkg::ST_REG_DATA;
					end
				end
			end
			usb_cmd_pkg::ST_REG_DATA: begin
				if (take) begin
					wr_reject_q <= !action_hit;
					state_q <= usb_cmd_pkg::ST_IDLE;
				end
			end
			usb_cmd_pkg::ST_STK_WR: begin
				if (take) begin
					if (room) begin
						ptr_q <= ptr_inc;
					end
					if (in_last) begin
						state_q <= usb_cmd_pkg::ST_IDLE;
					end
				end
			end
			usb_cmd_pkg::ST_STK_SEL: begin
				if (take) begin
					sel_q <= (in_data == usb_cmd_pkg::STACK_PERIODIC);
					ptr_q <= '0;
					state_q <= is_stack(in_data) ?
						usb_cmd_pkg::ST_STK_RD : usb_cmd_pkg::ST_DONE;
				end
			end
			usb_cmd_pkg::ST_STK_RD: begin
				state_q <= (ptr_q == cur_len) ?
					usb_cmd_pkg::ST_DONE : usb_cmd_pkg::ST_STK_PUT;
			end
			usb_cmd_pkg::ST_STK_PUT: begin
				out_data_q <= stk_rd_data;
				out_valid_q <= 1'b1;
				ptr_q <= ptr_inc;
				ret_q <= usb_cmd_pkg::ST_STK_RD;
				state_q <= usb_cmd_pkg::ST_PUSH;
			end
			usb_cmd_pkg::ST_EXE_CNT: begin
				if (take) begin
					rem_q <= in_data[15:1]; // byte count to words
					state_q <= (in_data[15:1] == 15'h0000) ?
						usb_cmd_pkg::ST_TERM : usb_cmd_pkg::ST_EXE_CMD;
				end
			end
			usb_cmd_pkg::ST_EXE_CMD: begin
				if (take) begin
					crate_cmd_q <= in_data;
					crate_req_q <= 1'b1;
					state_q <= usb_cmd_pkg::ST_EXE_WAIT;
				end
			end
			usb_cmd_pkg::ST_EXE_WAIT: begin
				if (crate_ack) begin
					out_data_q <= crate_rdata;
					out_valid_q <= 1'b1;
					rem_q <= rem_q - 15'h0001;
					ret_q <= (rem_q == 15'h0001) ?
						usb_cmd_pkg::ST_TERM : usb_cmd_pkg::ST_EXE_CMD;
					state_q <= usb_cmd_pkg::ST_PUSH;
				end
			end
			usb_cmd_pkg::ST_TERM: begin
				out_data_q <= usb_cmd_pkg::EVENT_TERMINATOR;
				out_valid_q <= 1'b1;
				ret_q <= usb_cmd_pkg::ST_DONE;
				state_q <= usb_cmd_pkg::ST_PUSH;
			end
			usb_cmd_pkg::ST_PUSH: begin
				if (out_ready) begin
					out_valid_q <= 1'b0;
					state_q <= ret_q;
				end
			end
			usb_cmd_pkg::ST_DONE: begin
				resp_full_q <= 1'b1;
				state_q <= usb_cmd_pkg::ST_IDLE;
			end
			default: begin
				state_q <= usb_cmd_pkg::ST_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign out_valid = out_valid_q;
	assign out_data = out_data_q;
	assign resp_full = resp_full_q;
	assign wr_reject = wr_reject_q;
	assign action = action_q;
	assign acq_active = action_q[usb_cmd_pkg::ACQ_START_BIT];
	assign logic_reset = logic_reset_q;
	assign crate_req = crate_req_q;
	assign crate_cmd = crate_cmd_q;
endmodule : usb_cmd_interp

// [rtl/usb_cmd_pkg.sv]
// constants shared by the usb command interpreter and its stack memories
// assumes one clock domain and 16-bit words on both usb fifos
//
// Operation
// - one host register only, the action register at address 1.
// - register-write buffer stores its data into the addressed register.
// - write to a read-only address changes nothing, reports zero accepted.
// - register read queues the register value as one 2-byte word.
// - stack write fills block ram; type 2 regular, type 3 periodic.
// - stack write is one header word then the stack words.
// - regular stack holds 768 words of 16 bits.
// - periodic stack holds 256 words of 16 bits.
// - stack words are stored unchecked, any value allowed.
// - stack read copies the stored words into the output fifo.
// - execute buffer commands run at once, their data queued out.
// - executed data is followed by terminator word 0xFF.
// - in programming mode reset-toggle inverts the logic reset.
// - full flag marks a queued response; host read waits or times out.
// - action bit 0 set starts acquisition, cleared ends it.
package usb_cmd_pkg;
	localparam int WORD_W = 16;
	localparam logic [15:0] ACTION_ADDR = 16'h0001;
	localparam logic [15:0] ACTION_RESET = 16'h0000;
	localparam int ACQ_START_BIT = 0;
	localparam logic [15:0] STACK_REGULAR = 16'h0002;
	localparam logic [15:0] STACK_PERIODIC = 16'h0003;
	localparam int REGULAR_DEPTH = 768;
	localparam int REGULAR_AW = 10;
	localparam int PERIODIC_DEPTH = 256;
	localparam int PERIODIC_AW = 8;
	localparam int LEN_W = 10;
	localparam logic [15:0] EVENT_TERMINATOR = 16'h00FF;
	localparam logic [15:0] READ_FILL = 16'h0000;
	// command codes of the leading buffer word
	localparam logic [15:0] CMD_REG_WRITE = 16'h0010;
	localparam logic [15:0] CMD_REG_READ = 16'h0011;
	localparam logic [15:0] CMD_STACK_READ = 16'h0012;
	localparam logic [15:0] CMD_EXECUTE = 16'h0013;
	localparam logic [15:0] CMD_RESET_TOGGLE = 16'h0014;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_REG_ADDR = 4'h1,
		ST_REG_DATA = 4'h3,
		ST_STK_WR = 4'h2,
		ST_STK_SEL = 4'h6,
		ST_STK_RD = 4'h7,
		ST_STK_PUT = 4'h5,
		ST_EXE_CNT = 4'h4,
		ST_EXE_CMD = 4'hC,
		ST_EXE_WAIT = 4'hD,
		ST_PUSH = 4'hF,
		ST_TERM = 4'hE,
		ST_DONE = 4'hA
	} cmd_state_e;
endpackage : usb_cmd_pkg

// [rtl/stack_ram.sv]
// one command stack memory, one write port and one registered read port
// assumes write and read addresses are in range when used
`timescale 1ns/100ps
module stack_ram #(
	parameter int DEPTH = 256,
	parameter int AW = 8
) (
	input wire logic clk, // device clock
	input wire logic wr_en, // write strobe
	input wire logic [AW-1:0] wr_addr, // write word address
	input wire logic [15:0] wr_data, // word to store
	input wire logic [AW-1:0] rd_addr, // read word address
	output logic [15:0] rd_data // word one cycle after address
);
	logic [15:0] mem [0:DEPTH-1];

	// store any word, read back one cycle later
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule : stack_ram

// [verif/usb_cmd_interp_sva.sv]
// port checker for the usb command interpreter
// assumes one clock domain, bound to every usb_cmd_interp
`timescale 1ns/100ps
module usb_cmd_interp_chk (
	input wire logic clk, // device clock
	input wire logic sys_rst, // sync reset
	input wire logic in_valid, // input word present
	input wire logic in_ready, // input word taken
	input wire logic out_valid, // response word offered
	input wire logic [15:0] out_data, // response word
	input wire logic out_ready, // host accepts
	input wire logic resp_full, // response queued
	input wire logic wr_reject, // write refused
	input wire logic [15:0] action, // action register
	input wire logic acq_active, // acquisition running
	input wire logic prog_mode, // programming position
	input wire logic logic_reset, // logic reset level
	input wire logic crate_req // crate request
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_reject_one_cycle: assert property (wr_reject |=> !wr_reject)
		else $error("reject pulse too long");
	a_reject_keeps_action: assert property (
		wr_reject |-> action == $past(action))
		else $error("refused write changed action");
	a_acq_bit_zero: assert property (
		(acq_active == action[0]) and
		($changed(action) |-> $past(in_valid && in_ready)))
		else $error("acquisition flag or action moved without host word");
	a_out_word_held: assert property (
		out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("response word dropped or changed");
	a_busy_no_take: assert property (out_valid |-> !in_ready)
		else $error("input taken while responding");
	a_req_one_cycle: assert property (crate_req |=> !crate_req)
		else $error("crate request too long");
	a_full_drops_next: assert property (
		resp_full && in_valid && in_ready |=> !resp_full)
		else $error("full flag kept after new buffer");
	a_toggle_prog_only: assert property (
		logic_reset != $past(logic_reset) |-> $past(prog_mode))
		else $error("logic reset moved outside programming");
endmodule : usb_cmd_interp_chk

bind usb_cmd_interp usb_cmd_interp_chk chk (.clk, .sys_rst, .in_valid,
	.in_ready, .out_valid, .out_data, .out_ready, .resp_full, .wr_reject,
	.action, .acq_active, .prog_mode, .logic_reset, .crate_req);

// [verif/host_model.sv]
// host model: sends queued buffer words, drains response words
// assumes the bench fills tx and reads rx between buffers
`timescale 1ns/100ps
module host_model (
	input wire logic clk, // device clock
	output logic in_valid, // word offered
	output logic [15:0] in_data, // offered word
	output logic in_last, // word ends buffer
	input wire logic in_ready, // block takes word
	input wire logic out_valid, // response word offered
	input wire logic [15:0] out_data, // response word
	output logic out_ready, // host accepts
	input wire logic slow // stall every other cycle
);
	logic [16:0] tx[$];
	logic [15:0] rx[$];
	logic [15:0] last_q = 16'h0000;
	logic ph = 1'b0;
	initial begin
		in_valid = 1'b0;
		in_data = 16'hFFFF;
		in_last = 1'b0;
		out_ready = 1'b0;
	end
	// bulk writes and bulk reads, both just after each edge
	always @(posedge clk) begin
		if (in_valid && in_ready) begin
			last_q = tx[0][15:0];
			void'(tx.pop_front());
		end
		if (out_valid && out_ready)
			rx.push_back(out_data);
		#1;
		ph = ~ph;
		out_ready = !slow || ph;
		in_valid = tx.size() != 0;
		in_data = in_valid ? tx[0][15:0] : ~last_q;
		in_last = in_valid && tx[0][16];
	end
endmodule : host_model

// [verif/testbench.sv]
// self-checking bench for the usb command interpreter
// assumes host_model and the bound checker are compiled alongside
`timescale 1ns/100ps
module testbench;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic prog_mode = 1'b0;
	logic slow = 1'b0;
	logic crate_ack = 1'b0;
	logic [15:0] crate_rdata = 16'h0000;
	logic in_valid, in_last, in_ready, out_valid, out_ready, resp_full;
	logic wr_reject, acq_active, logic_reset, crate_req;
	logic [15:0] in_data, out_data, action, crate_cmd;
	int miscompares = 0, checks = 0, cycles = 0, rejects = 0, dly = 0;
	usb_cmd_interp DUT (.clk, .sys_rst, .in_valid, .in_data, .in_last,
		.in_ready, .out_valid, .out_data, .out_ready, .resp_full, .wr_reject,
		.action, .acq_active, .prog_mode, .logic_reset, .crate_req,
		.crate_cmd, .crate_ack, .crate_rdata);
	host_model host (.clk, .in_valid, .in_data, .in_last, .in_ready,
		.out_valid, .out_data, .out_ready, .slow);
	initial forever #4 clk = ~clk;
	// crate bus answers three cycles after a request; watchdog
	always @(posedge clk) begin
		#1;
		crate_ack = dly == 1;
		crate_rdata = crate_ack ? crate_cmd ^ 16'h5A5A : ~crate_rdata;
		dly = crate_req ? 3 : (dly != 0 ? dly - 1 : 0);
		if (wr_reject === 1'b1)
			rejects++;
		if (cycles++ > 30000) begin
			miscompares++;
			give_verdict();
		end
	end
	task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task run(input logic [15:0] w[$], input bit resp);
		int n;
		int m;
		host.rx.delete();
		foreach (w[i]) host.tx.push_back({i == w.size() - 1, w[i]});
		for (n = 0; host.tx.size() != 0 && n < 2000; n++) @(posedge clk) #1;
		for (m = 0; resp && resp_full !== 1'b1 && m < 5000; m++)
			@(posedge clk) #1;
		// a stuck buffer or a missing response counts against the run
		if (n >= 2000 || m >= 5000) begin
			miscompares++;
			$display("MISMATCH %0t buffer or response timed out", $time);
		end
		repeat (4) @(posedge clk) #1;
	endtask : run
	task t_regs;
		chk(action, 16'h0000, "action reset");
		run('{16'h0010, 16'h0001, 16'hA5C3}, 0);
		chk(action, 16'hA5C3, "action write");
		chk({15'h0, acq_active}, 16'h0001, "acq on");
		run('{16'h0010, 16'h0002, 16'h1234}, 0);
		chk(action, 16'hA5C3, "refused write");
		chk(16'(rejects), 16'h0001, "reject pulse");
		run('{16'h0011, 16'h0001}, 1);
		chk({15'h0, resp_full}, 16'h0001, "full flag");
		chk(16'(host.rx.size()), 16'h0001, "read length");
		chk(host.rx[0], 16'hA5C3, "read value");
		run('{16'h0011, 16'h0002}, 1);
		chk(16'(host.rx.size()), 16'h0001, "fill length");
		chk(host.rx[0], 16'h0000, "fill value");
		run('{16'h0010, 16'h0001, 16'h0000}, 0);
		chk({15'h0, acq_active}, 16'h0000, "acq off");
		$display("test regs done");
	endtask : t_regs
	task t_stack;
		logic [15:0] w[$];
		slow = 1'b1;
		w = '{16'h0002};
		for (int i = 0; i < 769; i++) w.push_back(16'(i));
		run(w, 0);
		run('{16'h0012, 16'h0002}, 1);
		chk(16'(host.rx.size()), 16'h0300, "regular depth");
		chk(host.rx[767], 16'h02FF, "regular top");
		run('{16'h0002, 16'h0000, 16'hFFFF, 16'h8001}, 0);
		run('{16'h0003, 16'h7E7E}, 0);
		run('{16'h0012, 16'h0002}, 1);
		chk(16'(host.rx.size()), 16'h0003, "regular length");
		chk(host.rx[1], 16'hFFFF, "any word kept");
		chk(host.rx[2], 16'h8001, "regular word");
		run('{16'h0012, 16'h0003}, 1);
		chk(16'(host.rx.size()), 16'h0001, "periodic length");
		chk(host.rx[0], 16'h7E7E, "periodic word");
		run('{16'h0012, 16'h0005}, 1);
		chk(16'(host.rx.size()), 16'h0000, "bad type length");
		chk({15'h0, resp_full}, 16'h0001, "bad type full");
		slow = 1'b0;
		$display("test stack done");
	endtask : t_stack
	task t_exec;
		run('{16'h0013, 16'h0004, 16'h1111, 16'h2222}, 1);
		chk(16'(host.rx.size()), 16'h0003, "exec length");
		chk(host.rx[0], 16'h4B4B, "exec data 0");
		chk(host.rx[1], 16'h7878, "exec data 1");
		chk(host.rx[2], 16'h00FF, "terminator");
		run('{16'h0013, 16'h0000}, 1);
		chk(16'(host.rx.size()), 16'h0001, "empty exec length");
		chk(host.rx[0], 16'h00FF, "empty exec term");
		$display("test exec done");
	endtask : t_exec
	task t_toggle;
		run('{16'h0014}, 0);
		chk({15'h0, logic_reset}, 16'h0000, "no prog");
		prog_mode = 1'b1;
		run('{16'h0014}, 0);
		chk({15'h0, logic_reset}, 16'h0001, "toggle on");
		run('{16'h0014}, 0);
		chk({15'h0, logic_reset}, 16'h0000, "toggle off");
		$display("test toggle done");
	endtask : t_toggle
	task give_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (4) @(posedge clk);
		#1 sys_rst = 1'b0;
		t_regs();
		t_stack();
		t_exec();
		t_toggle();
		give_verdict();
	end
endmodule : testbench
